/* include/tcs_consts.svh */
// constants for the transaction check-value sequencer
`ifndef TCS_CONSTS_SVH
`define TCS_CONSTS_SVH

// ==================================================
// generator
`define TCS_CRC_POLY 16'hA001
`define TCS_CRC_INIT 16'h0000
`define TCS_BITS_LAST 4'hF

// ==================================================
// byte positions within a command
`define TCS_IDX_CTL1 3'h1
`define TCS_IDX_WR_DATA 3'h3
`define TCS_IDX_DATA 3'h4

// ==================================================
// channel control byte 1 check-value option field
`define TCS_OPT_LSB 2
`define TCS_OPT_NONE 2'h0
`define TCS_OPT_1 2'h1
`define TCS_OPT_8 2'h2
`define TCS_OPT_32 2'h3
`define TCS_BLK_1 6'h01
`define TCS_BLK_8 6'h08
`define TCS_BLK_32 6'h20

`endif

/* include/tcs_pkg.sv */
// types for the transaction check-value sequencer
package tcs_pkg;
    // kind of command being tracked
    typedef enum logic [2:0] {
        TCS_OP_RD_MEM = 3'h0,
        TCS_OP_RD_STAT = 3'h1,
        TCS_OP_EXT_RD = 3'h2,
        TCS_OP_WRITE = 3'h3,
        TCS_OP_CHAN = 3'h4
    } tcs_op_e;
    // accumulate, then send the check value
    typedef enum logic {
        TCS_ST_ACC = 1'b0,
        TCS_ST_SEND = 1'b1
    } tcs_state_e;
endpackage : tcs_pkg

/* design/tcs_crc16_seq.sv */
// check-value sequencer: decides what is accumulated and when it is sent
`timescale 1ns/1ps
`default_nettype none
`include "tcs_consts.svh"

// Summary of operation
// - memory read sends one check value after the last implemented data byte
// - status read sends check value after status page, from cleared generator
// - redirected read: check value after each redirect byte, first covers header
// - later redirect passes clear and accumulate only the new redirect byte
// - page end check value covers that page's bytes from a cleared generator
// - first write byte: clear, accumulate command, address, data, then send
// - later write bytes load incremented address into generator, then data
// - channel control byte 1 picks none, every 1, 8 or 32 bytes
// - first channel check value covers command, controls, info and data block
// - later channel check values cover only new data bytes, cleared first
// - a check value mismatch never stops or alters the command sequence
// - generator is x^16+x^15+x^2+1 with data xored into the last stage
// - check value always leaves inverted
module tcs_crc16_seq
    import tcs_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic cmd_start_in,
    input wire tcs_op_e op_in,
    input wire logic byte_stb_in,
    input wire logic [7:0] byte_in,
    input wire logic byte_last_in,
    input wire logic byte_redir_in,
    input wire logic [15:0] addr_in,
    input wire logic bit_slot_in,
    output logic crc_valid_out,
    output logic tx_bit_out,
    output logic [15:0] crc_word_out
);

    // ==================================================
    // helpers

    // one byte through the reflected generator, lsb first
    function automatic logic [15:0] tcs_crc_byte(input logic [15:0] c, input logic [7:0] d);
        logic [15:0] r;
        logic fb;
        r = c;
        for (int i = 0; i < 8; i++) begin
            fb = r[0] ^ d[i];
            r = {1'b0, r[15:1]};
            if (fb) begin
                r = r ^ `TCS_CRC_POLY;
            end
        end
        return r;
    endfunction : tcs_crc_byte

    // data bytes per check value for a channel option
    function automatic logic [5:0] tcs_blk(input logic [1:0] opt);
        logic [5:0] b;
        unique case (opt)
            `TCS_OPT_1: b = `TCS_BLK_1;
            `TCS_OPT_8: b = `TCS_BLK_8;
            default: b = `TCS_BLK_32;
        endcase
        return b;
    endfunction : tcs_blk

    // ==================================================
    // state

    tcs_state_e st_q, st_d;
    tcs_op_e op_q, op_d;
    logic [15:0] crc_q, crc_d;
    logic [15:0] sh_q, sh_d;
    logic [15:0] word_q, word_d;
    logic [3:0] bits_q, bits_d;
    logic [2:0] idx_q, idx_d;
    logic [5:0] cnt_q, cnt_d;
    logic [1:0] opt_q, opt_d;
    logic wr_more_q, wr_more_d;

    // next-state logic; bytes offered while sending are ignored by design
    always_comb begin
        logic [15:0] nxt;
        logic snd;
        logic [5:0] cnt_n;
        nxt = crc_q;
        snd = 1'b0;
        cnt_n = 6'h00;
        st_d = st_q;
        op_d = op_q;
        crc_d = crc_q;
        sh_d = sh_q;
        word_d = word_q;
        bits_d = bits_q;
        idx_d = idx_q;
        cnt_d = cnt_q;
        opt_d = opt_q;
        wr_more_d = wr_more_q;
        if (cmd_start_in) begin
            // every command begins from a cleared generator
            st_d = TCS_ST_ACC;
            op_d = op_in;
            crc_d = `TCS_CRC_INIT;
            idx_d = 3'h0;
            cnt_d = 6'h00;
            opt_d = `TCS_OPT_NONE;
            wr_more_d = 1'b0;
            bits_d = 4'h0;
        end else begin
            unique case (st_q)
                TCS_ST_ACC: begin
                    if (byte_stb_in) begin
                        if (op_q == TCS_OP_WRITE && wr_more_q) begin
                            nxt = tcs_crc_byte(addr_in, byte_in);
                        end else begin
                            nxt = tcs_crc_byte(crc_q, byte_in);
                        end
                        crc_d = nxt;
                        if (idx_q != `TCS_IDX_DATA) begin
                            idx_d = idx_q + 3'h1;
                        end
                        unique case (op_q)
                            TCS_OP_RD_MEM: snd = byte_last_in;
                            TCS_OP_RD_STAT: snd = byte_last_in;
                            TCS_OP_EXT_RD: snd = byte_redir_in || byte_last_in;
                            TCS_OP_WRITE: snd = wr_more_q || (idx_q == `TCS_IDX_WR_DATA);
                            TCS_OP_CHAN: begin
                                if (idx_q == `TCS_IDX_CTL1) begin
                                    opt_d = byte_in[`TCS_OPT_LSB +: 2];
                                end
                                if (idx_q == `TCS_IDX_DATA && opt_q != `TCS_OPT_NONE) begin
                                    cnt_n = cnt_q + 6'h01;
                                    snd = (cnt_n == tcs_blk(opt_q));
                                    cnt_d = snd ? 6'h00 : cnt_n;
                                end
                            end
                            default: snd = 1'b0; // illegal op code: accumulate only
                        endcase
                        if (snd) begin
                            st_d = TCS_ST_SEND;
                            word_d = ~nxt;
                            sh_d = ~nxt;
                            bits_d = 4'h0;
                        end
                    end
                end
                TCS_ST_SEND: begin
                    if (bit_slot_in) begin
                        sh_d = {1'b0, sh_q[15:1]};
                        bits_d = bits_q + 4'h1;
                        if (bits_q == `TCS_BITS_LAST) begin
                            // next segment starts clean; writes reload the address
                            st_d = TCS_ST_ACC;
                            crc_d = `TCS_CRC_INIT;
                            wr_more_d = (op_q == TCS_OP_WRITE);
                        end
                    end
                end
            endcase
        end
    end

    // registers; no mismatch input exists, so the sequence never stalls
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            st_q <= TCS_ST_ACC;
            op_q <= TCS_OP_RD_MEM;
            crc_q <= `TCS_CRC_INIT;
            sh_q <= 16'h0000;
            word_q <= 16'h0000;
            bits_q <= 4'h0;
            idx_q <= 3'h0;
            cnt_q <= 6'h00;
            opt_q <= `TCS_OPT_NONE;
            wr_more_q <= 1'b0;
        end else begin
            st_q <= st_d;
            op_q <= op_d;
            crc_q <= crc_d;
            sh_q <= sh_d;
            word_q <= word_d;
            bits_q <= bits_d;
            idx_q <= idx_d;
            cnt_q <= cnt_d;
            opt_q <= opt_d;
            wr_more_q <= wr_more_d;
        end
    end

    // outputs straight from flops
    assign crc_valid_out = (st_q == TCS_ST_SEND);
    assign tx_bit_out = sh_q[0];
    assign crc_word_out = word_q;

    // ==================================================
    // assertions

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    logic acc_take;
    assign acc_take = byte_stb_in && !cmd_start_in && st_q == TCS_ST_ACC;

    property p_rd_mem_send;
        acc_take && op_q == TCS_OP_RD_MEM && byte_last_in |=> crc_valid_out;
    endproperty
    a_rd_mem_send: assert property (p_rd_mem_send) else $error("no value after last byte");

    property p_stat_clear;
        cmd_start_in && op_in == TCS_OP_RD_STAT |=> crc_q == `TCS_CRC_INIT && !crc_valid_out;
    endproperty
    a_stat_clear: assert property (p_stat_clear) else $error("status read not cleared");

    property p_redir_send;
        acc_take && op_q == TCS_OP_EXT_RD && byte_redir_in
            |=> crc_valid_out && crc_word_out == ~crc_q;
    endproperty
    a_redir_send: assert property (p_redir_send) else $error("no value after redirect");

    property p_ext_clear;
        crc_valid_out && bit_slot_in && bits_q == `TCS_BITS_LAST && op_q == TCS_OP_EXT_RD
            && !cmd_start_in |=> !crc_valid_out && crc_q == `TCS_CRC_INIT;
    endproperty
    a_ext_clear: assert property (p_ext_clear) else $error("generator not cleared");

    property p_wr_first;
        acc_take && op_q == TCS_OP_WRITE && !wr_more_q && idx_q == `TCS_IDX_WR_DATA
            |=> crc_valid_out;
    endproperty
    a_wr_first: assert property (p_wr_first) else $error("write value missing");

    property p_wr_load;
        acc_take && op_q == TCS_OP_WRITE && wr_more_q
            |=> crc_word_out == ~tcs_crc_byte($past(addr_in), $past(byte_in));
    endproperty
    a_wr_load: assert property (p_wr_load) else $error("address not loaded");

    property p_opt_latch;
        acc_take && op_q == TCS_OP_CHAN && idx_q == `TCS_IDX_CTL1
            |=> opt_q == $past(byte_in[`TCS_OPT_LSB +: 2]);
    endproperty
    a_opt_latch: assert property (p_opt_latch) else $error("option not taken");

    property p_chan_none;
        op_q == TCS_OP_CHAN && opt_q == `TCS_OPT_NONE && !crc_valid_out && !cmd_start_in
            |=> !crc_valid_out;
    endproperty
    a_chan_none: assert property (p_chan_none) else $error("value sent with option none");

    property p_accum;
        acc_take && !(op_q == TCS_OP_WRITE && wr_more_q)
            |=> crc_q == tcs_crc_byte($past(crc_q), $past(byte_in));
    endproperty
    a_accum: assert property (p_accum) else $error("generator step wrong");

    // the first bit on the wire is bit 0 of the inverted value just captured
    property p_lsb_first;
        $rose(crc_valid_out) |-> tx_bit_out == crc_word_out[0] && crc_word_out == ~crc_q;
    endproperty
    a_lsb_first: assert property (p_lsb_first) else $error("first bit not lsb");

    // each used slot moves the next higher bit onto the wire
    property p_shift_next;
        crc_valid_out && bit_slot_in && !cmd_start_in && bits_q != `TCS_BITS_LAST
            |=> crc_valid_out && tx_bit_out == $past(sh_q[1]);
    endproperty
    a_shift_next: assert property (p_shift_next) else $error("serial bit order wrong");

    // the sixteenth slot ends the send and leaves a cleared generator
    property p_send_end;
        crc_valid_out && bit_slot_in && !cmd_start_in && bits_q == `TCS_BITS_LAST
            |=> !crc_valid_out && crc_q == `TCS_CRC_INIT;
    endproperty
    a_send_end: assert property (p_send_end) else $error("send did not end clean");

    // bytes offered while sending leave generator and shifter untouched
    property p_refuse;
        crc_valid_out && byte_stb_in && !bit_slot_in && !cmd_start_in
            |=> $stable(crc_q) && $stable(sh_q) && crc_valid_out;
    endproperty
    a_refuse: assert property (p_refuse) else $error("strobe taken while sending");

    // the status page end always triggers a send of the inverted value
    property p_stat_send;
        acc_take && op_q == TCS_OP_RD_STAT && byte_last_in
            |=> crc_valid_out && crc_word_out == ~crc_q;
    endproperty
    a_stat_send: assert property (p_stat_send) else $error("no value after status page");

    // a full data block of the chosen size triggers a channel send
    property p_chan_send;
        acc_take && op_q == TCS_OP_CHAN && idx_q == `TCS_IDX_DATA && opt_q != `TCS_OPT_NONE
            && cnt_q + 6'h01 == tcs_blk(opt_q) |=> crc_valid_out;
    endproperty
    a_chan_send: assert property (p_chan_send) else $error("channel block not closed");

    // the captured value stands until the next send begins
    property p_word_hold;
        !$rose(crc_valid_out) |-> $stable(crc_word_out);
    endproperty
    a_word_hold: assert property (p_word_hold) else $error("check value changed early");

    c_rd_mem: cover property (acc_take && op_q == TCS_OP_RD_MEM && byte_last_in);
    c_ext_redir: cover property (acc_take && op_q == TCS_OP_EXT_RD && byte_redir_in);
    c_wr_more: cover property (acc_take && op_q == TCS_OP_WRITE && wr_more_q);
    c_chan_blk: cover property (op_q == TCS_OP_CHAN && $rose(crc_valid_out));
    c_abort: cover property (crc_valid_out && cmd_start_in);

endmodule : tcs_crc16_seq
`default_nettype wire

/* bench/tcs_master_model.sv */
// bus master model: clocks out check-value bits and collects them
`timescale 1ns/1ps
`default_nettype none
module tcs_master_model (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic crc_valid_in,
    input wire logic tx_bit_in,
    input wire logic [3:0] gap_in,
    output logic bit_slot_out,
    output logic [15:0] word_out,
    output logic [4:0] bits_out
);
    logic valid_q;
    logic [3:0] wait_q;
    // ==================================================
    // slot pacing; never two slots back to back, gap_in makes a slow master
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            valid_q <= 1'b0;
            wait_q <= 4'h0;
            bit_slot_out <= 1'b0;
            word_out <= 16'h0000;
            bits_out <= 5'h00;
        end else begin
            valid_q <= crc_valid_in;
            if (crc_valid_in && !valid_q) begin
                bits_out <= 5'h00;
                wait_q <= gap_in;
            end else if (bit_slot_out) begin
                word_out <= {tx_bit_in, word_out[15:1]};
                bits_out <= bits_out + 5'h01;
                bit_slot_out <= 1'b0;
                wait_q <= gap_in;
            end else if (wait_q != 4'h0) begin
                wait_q <= wait_q - 4'h1;
            end else if (crc_valid_in && bits_out < 5'h10) begin
                bit_slot_out <= 1'b1;
            end
        end
    end
endmodule : tcs_master_model
`default_nettype wire

/* bench/tcs_crc16_seq_bench.sv */
// self-checking bench for the check-value sequencer
`timescale 1ns/1ps
`default_nettype none
module tcs_crc16_seq_bench;
    import tcs_pkg::*;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic cmd_start = 1'b0;
    tcs_op_e op = TCS_OP_RD_MEM;
    logic byte_stb = 1'b0;
    logic [7:0] byte_v = 8'h00;
    logic byte_last = 1'b0;
    logic byte_redir = 1'b0;
    logic [15:0] addr = 16'h0000;
    logic [3:0] gap = 4'h0;
    logic bit_slot;
    logic crc_valid;
    logic tx_bit;
    logic [15:0] crc_word;
    logic [15:0] m_word;
    logic [4:0] m_bits;
    logic [15:0] crc;
    int n_fail = 0;
    int checked = 0;

    // ==================================================
    // clock and units
    always #5 clk_in = ~clk_in;

    tcs_crc16_seq tcs_crc16_seq_inst (.clk_in(clk_in), .rst_in(rst_in),
        .cmd_start_in(cmd_start), .op_in(op), .byte_stb_in(byte_stb), .byte_in(byte_v),
        .byte_last_in(byte_last), .byte_redir_in(byte_redir), .addr_in(addr),
        .bit_slot_in(bit_slot), .crc_valid_out(crc_valid), .tx_bit_out(tx_bit),
        .crc_word_out(crc_word));

    tcs_master_model tcs_master_model_inst (.clk_in(clk_in), .rst_in(rst_in),
        .crc_valid_in(crc_valid), .tx_bit_in(tx_bit), .gap_in(gap),
        .bit_slot_out(bit_slot), .word_out(m_word), .bits_out(m_bits));

    // ==================================================
    // helpers; the reference generator is kept apart from the design's own
    function automatic logic [15:0] step(input logic [15:0] c, input logic [7:0] b);
        logic fb;
        for (int i = 0; i < 8; i++) begin
            fb = c[0] ^ b[i];
            c = c >> 1;
            if (fb) begin
                c = c ^ 16'hA001;
            end
        end
        return c;
    endfunction : step

    task automatic check(input logic [15:0] got, input logic [15:0] want);
        checked++;
        if (got !== want) begin
            n_fail++;
            $display("FAIL t=%0t got=%h want=%h", $time, got, want);
        end
    endtask : check

    task automatic start(input tcs_op_e o);
        @(posedge clk_in);
        cmd_start <= 1'b1;
        op <= o;
        @(posedge clk_in);
        cmd_start <= 1'b0;
        crc = 16'h0000;
    endtask : start

    // one byte strobe; s says whether a check value must follow it
    task automatic put(input logic [7:0] b, input logic l, input logic r, input logic s);
        int n;
        @(posedge clk_in);
        byte_stb <= 1'b1;
        byte_v <= b;
        byte_last <= l;
        byte_redir <= r;
        @(posedge clk_in);
        byte_stb <= 1'b0;
        byte_last <= 1'b0;
        byte_redir <= 1'b0;
        crc = step(crc, b);
        #1;
        check({15'h0000, crc_valid}, {15'h0000, s});
        if (s) begin
            n = 0;
            while (crc_valid === 1'b1 && n < 400) begin
                @(posedge clk_in);
                #1;
                n++;
            end
            check(m_word, ~crc);
            check(crc_word, ~crc);
            check({11'h000, m_bits}, 16'h0010);
            crc = 16'h0000;
        end
    endtask : put

    task automatic hdr(input logic [7:0] c, input logic [7:0] lo, input logic [7:0] hi);
        put(c, 1'b0, 1'b0, 1'b0);
        put(lo, 1'b0, 1'b0, 1'b0);
        put(hi, 1'b0, 1'b0, 1'b0);
    endtask : hdr

    // ==================================================
    // scenarios
    task automatic t_reads();
        start(TCS_OP_RD_MEM);
        hdr(8'hF0, 8'h05, 8'h00);
        for (int i = 0; i < 5; i++) begin
            put(8'hA0 + 8'(i), i == 4, 1'b0, i == 4);
        end
        start(TCS_OP_RD_STAT);
        hdr(8'hAA, 8'h00, 8'h00);
        for (int i = 0; i < 8; i++) begin
            put(8'h3C ^ 8'(i), i == 7, 1'b0, i == 7);
        end
    endtask : t_reads

    task automatic t_ext_rd();
        start(TCS_OP_EXT_RD);
        hdr(8'hA5, 8'h1C, 8'h00);
        put(8'h40, 1'b0, 1'b1, 1'b1);
        for (int i = 0; i < 4; i++) begin
            put(8'h81 + 8'(i), i == 3, 1'b0, i == 3);
        end
        put(8'h60, 1'b0, 1'b1, 1'b1);
        put(8'hC7, 1'b0, 1'b0, 1'b0);
        put(8'h19, 1'b1, 1'b0, 1'b1);
    endtask : t_ext_rd

    // slow master here; each later byte reloads the incremented address
    task automatic t_write();
        gap = 4'h3;
        start(TCS_OP_WRITE);
        hdr(8'h0F, 8'hFF, 8'h00);
        put(8'h5A, 1'b0, 1'b0, 1'b1);
        for (int i = 1; i < 3; i++) begin
            @(posedge clk_in);
            addr <= 16'h00FF + 16'(i);
            crc = 16'h00FF + 16'(i);
            put(8'h96 - 8'(i), 1'b0, 1'b0, 1'b1);
        end
        gap = 4'h0;
    endtask : t_write

    // every option code of control byte 1, two blocks each
    task automatic t_chan();
        int n;
        for (int o = 0; o < 4; o++) begin
            n = (o == 0) ? 4 : (o == 1) ? 1 : (o == 2) ? 8 : 32;
            start(TCS_OP_CHAN);
            put(8'hF5, 1'b0, 1'b0, 1'b0);
            put({4'h0, 2'(o), 2'b00}, 1'b0, 1'b0, 1'b0);
            put(8'hFF, 1'b0, 1'b0, 1'b0);
            put(8'h4A, 1'b0, 1'b0, 1'b0);
            for (int k = 0; k < 2; k++) begin
                for (int j = 0; j < n; j++) begin
                    put(8'(j * 7 + k), 1'b0, 1'b0, o != 0 && j == n - 1);
                end
            end
        end
    endtask : t_chan

    // one byte marked last, offered without waiting for the send
    task automatic lone(input logic [7:0] b);
        @(posedge clk_in);
        byte_stb <= 1'b1;
        byte_v <= b;
        byte_last <= 1'b1;
        @(posedge clk_in);
        byte_stb <= 1'b0;
        byte_last <= 1'b0;
        crc = step(crc, b);
    endtask : lone

    // a strobe held into the send is dropped; a new command cuts a send short
    task automatic t_refuse();
        int n;
        start(TCS_OP_RD_STAT);
        hdr(8'hAA, 8'h07, 8'h00);
        @(posedge clk_in);
        byte_stb <= 1'b1;
        byte_v <= 8'h5E;
        byte_last <= 1'b1;
        @(posedge clk_in);
        byte_v <= 8'hC3;
        crc = step(crc, 8'h5E);
        @(posedge clk_in);
        byte_stb <= 1'b0;
        byte_last <= 1'b0;
        #1;
        check({15'h0000, crc_valid}, 16'h0001);
        n = 0;
        while (crc_valid === 1'b1 && n < 400) begin
            @(posedge clk_in);
            #1;
            n++;
        end
        check(m_word, ~crc);
        start(TCS_OP_RD_MEM);
        hdr(8'hF0, 8'h02, 8'h00);
        lone(8'h77);
        repeat (6) @(posedge clk_in);
        start(TCS_OP_RD_MEM);
        #1;
        check({15'h0000, crc_valid}, 16'h0000);
        hdr(8'hF0, 8'h02, 8'h00);
        put(8'h77, 1'b1, 1'b0, 1'b1);
    endtask : t_refuse

    // reset in mid-send brings every output back to its idle value
    task automatic t_reset();
        start(TCS_OP_RD_MEM);
        hdr(8'hF0, 8'h03, 8'h00);
        lone(8'h3E);
        repeat (5) @(posedge clk_in);
        rst_in <= 1'b1;
        repeat (2) @(posedge clk_in);
        #1;
        check({14'h0000, crc_valid, tx_bit}, 16'h0000);
        check(crc_word, 16'h0000);
        @(posedge clk_in);
        rst_in <= 1'b0;
        start(TCS_OP_RD_MEM);
        hdr(8'hF0, 8'h03, 8'h00);
        put(8'h3E, 1'b1, 1'b0, 1'b1);
    endtask : t_reset

    task automatic close_out();
        $display("checked=%0d n_fail=%0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : close_out

    // ==================================================
    // main sequence and watchdog; the run needs well under 10000 cycles
    initial begin
        repeat (16) @(posedge clk_in);
        rst_in <= 1'b0;
        #1;
        check(crc_word, 16'h0000);
        t_reads();
        t_ext_rd();
        t_write();
        t_chan();
        t_refuse();
        t_reset();
        close_out();
    end

    initial begin
        #500000;
        n_fail++;
        close_out();
    end
endmodule : tcs_crc16_seq_bench
`default_nettype wire
